// ==== verilog/rfa_map.svh ====
// register field access constants and functional notes
// Functional notes
// - A read-only field returns its live value and ignores every write.
// - A read-to-clear field returns its value, is cleared after the read, and ignores writes.
// - A write-only field stores writes and always reads back zero.
// - A write-one-to-clear field clears each bit written with one and keeps bits written with zero.
// - A latch-low status bit holds zero after its condition falls until a read releases it.
// - A latch-high status bit holds one after its condition rises until a read releases it.
// - A self-clearing bit goes back to zero by itself after being set, ignores zero writes, and reads back.
// - Signals with an active-low suffix, the chip reset among them, are asserted when low.
// - The host reaches all registers through the management port access path of this bank.
`ifndef RFA_MAP_SVH
`define RFA_MAP_SVH
`define RFA_ADDR_W 3
`define RFA_A_RO 3'h0
`define RFA_A_RC 3'h1
`define RFA_A_WO 3'h2
`define RFA_A_WC 3'h3
`define RFA_A_LL 3'h4
`define RFA_A_LH 3'h5
`define RFA_A_SC 3'h6
`define RFA_A_RSV 3'h7
`define RFA_DW 8
`define RFA_ZERO 8'h00
`define RFA_ONES 8'hff
`define RFA_SC_HOLD 2'h1
`endif

// ==== verilog/rfa_pkg.sv ====
// package for the register field access bank
package rfa_pkg;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } rfa_req_t;
  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
  } rfa_rsp_t;
endpackage : rfa_pkg

// ==== verilog/rfa_bank.sv ====
// one bank holding one field of each access type
`timescale 1ns/1ps
`include "rfa_map.svh"
module rfa_bank #(
  parameter int DW = `RFA_DW
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire rfa_pkg::rfa_req_t req,
  input wire logic [DW-1:0] ro_value,
  input wire logic [DW-1:0] rc_event,
  input wire logic [DW-1:0] ll_cond,
  input wire logic [DW-1:0] lh_cond,
  output rfa_pkg::rfa_rsp_t rsp,
  output logic [DW-1:0] wo_value,
  output logic [DW-1:0] sc_pulse
);
  import rfa_pkg::*;

  // reset pipeline; the pin is not timed to clk_sys
  logic rst_s1;
  logic rst_s2;

  // first and second stages of the pin synchronisers
  logic [DW-1:0] ro_s1;
  logic [DW-1:0] ro_s2;
  logic [DW-1:0] ev_s1;
  logic [DW-1:0] ev_s2;
  logic [DW-1:0] ll_s1;
  logic [DW-1:0] ll_s2;
  logic [DW-1:0] lh_s1;
  logic [DW-1:0] lh_s2;

  // field storage, one vector per access type except read-only and write-only
  logic [DW-1:0] rc_q;
  logic [DW-1:0] wc_q;
  logic [DW-1:0] ll_q;
  logic [DW-1:0] lh_q;
  logic [DW-1:0] sc_q;

  // decoded strobes, one per field that reacts to the host
  logic rd_rc;
  logic rd_ll;
  logic rd_lh;
  logic wr_wc;
  logic wr_sc;
  logic wr_wo;

  // true when a strobe hits one field address
  function automatic logic field_hit(
    input logic strobe,
    input logic [`RFA_ADDR_W-1:0] addr,
    input logic [`RFA_ADDR_W-1:0] field
  );
    return strobe && (addr == field);
  endfunction : field_hit

  // reset sync; low on pin means asserted
  always_ff @(posedge clk_sys) begin
    rst_s1 <= ~rst_n;
    rst_s2 <= rst_s1;
  end

  // first stage of every pin synchroniser
  always_ff @(posedge clk_sys) begin
    ro_s1 <= ro_value;
    ev_s1 <= rc_event;
    ll_s1 <= ll_cond;
    lh_s1 <= lh_cond;
  end

  // second stage; only these feed the field logic
  always_ff @(posedge clk_sys) begin
    ro_s2 <= ro_s1;
    ev_s2 <= ev_s1;
    ll_s2 <= ll_s1;
    lh_s2 <= lh_s1;
  end

  // read strobes that carry side effects
  assign rd_rc = field_hit(req.rd, req.addr, `RFA_A_RC);
  assign rd_ll = field_hit(req.rd, req.addr, `RFA_A_LL);
  assign rd_lh = field_hit(req.rd, req.addr, `RFA_A_LH);

  // write strobes; writes to other fields fall on the floor
  assign wr_wc = field_hit(req.wr, req.addr, `RFA_A_WC);
  assign wr_sc = field_hit(req.wr, req.addr, `RFA_A_SC);
  assign wr_wo = field_hit(req.wr, req.addr, `RFA_A_WO);

  // answer flag, one cycle after each read strobe
  always_ff @(posedge clk_sys) begin
    if (rst_s2) begin
      rsp.valid <= 1'b0;
    end else begin
      rsp.valid <= req.rd;
    end
  end

  // read data taken from the old field value, before side effects land
  always_ff @(posedge clk_sys) begin
    if (rst_s2) begin
      rsp.rdata <= `RFA_ZERO;
    end else if (req.rd) begin
      unique case (req.addr)
        `RFA_A_RO: rsp.rdata <= ro_s2;
        `RFA_A_RC: rsp.rdata <= rc_q;
        `RFA_A_WO: rsp.rdata <= `RFA_ZERO;
        `RFA_A_WC: rsp.rdata <= wc_q;
        `RFA_A_LL: rsp.rdata <= ll_q;
        `RFA_A_LH: rsp.rdata <= lh_q;
        `RFA_A_SC: rsp.rdata <= sc_q;
        `RFA_A_RSV: rsp.rdata <= `RFA_ZERO;
      endcase
    end
  end

  // per-bit field behaviour; bits of one field never interact
  for (genvar b = 0; b < DW; b++) begin : g_bit

    // read-to-clear: event sets, completed read clears, set wins
    always_ff @(posedge clk_sys) begin
      if (rst_s2) begin
        rc_q[b] <= 1'b0;
      end else if (ev_s2[b]) begin
        rc_q[b] <= 1'b1;
      end else if (rd_rc) begin
        rc_q[b] <= 1'b0;
      end
    end

    // write-one-to-clear: zero written keeps the bit, event wins
    always_ff @(posedge clk_sys) begin
      if (rst_s2) begin
        wc_q[b] <= 1'b0;
      end else if (ev_s2[b]) begin
        wc_q[b] <= 1'b1;
      end else if (wr_wc && req.wdata[b]) begin
        wc_q[b] <= 1'b0;
      end
    end

    // latch low: a low condition sticks until a read releases it
    always_ff @(posedge clk_sys) begin
      if (rst_s2) begin
        ll_q[b] <= 1'b1;
      end else if (rd_ll) begin
        ll_q[b] <= ll_s2[b];
      end else if (!ll_s2[b]) begin
        ll_q[b] <= 1'b0;
      end
    end

    // latch high: a high condition sticks until a read releases it
    always_ff @(posedge clk_sys) begin
      if (rst_s2) begin
        lh_q[b] <= 1'b0;
      end else if (rd_lh) begin
        lh_q[b] <= lh_s2[b];
      end else if (lh_s2[b]) begin
        lh_q[b] <= 1'b1;
      end
    end

    // self-clearing: a one lives one cycle, a zero write does nothing
    always_ff @(posedge clk_sys) begin
      if (rst_s2) begin
        sc_q[b] <= 1'b0;
      end else if (wr_sc && req.wdata[b]) begin
        sc_q[b] <= 1'b1;
      end else begin
        sc_q[b] <= 1'b0;
      end
    end
  end

  // write-only value; the host cannot read it back
  always_ff @(posedge clk_sys) begin
    if (rst_s2) begin
      wo_value <= `RFA_ZERO;
    end else if (wr_wo) begin
      wo_value <= req.wdata;
    end
  end

  // self-clearing action pulse, mirrors the field's set cycle
  always_ff @(posedge clk_sys) begin
    if (rst_s2) begin
      sc_pulse <= `RFA_ZERO;
    end else if (wr_sc) begin
      sc_pulse <= req.wdata;
    end else begin
      sc_pulse <= `RFA_ZERO;
    end
  end

  // hazards worth knowing for integration:
  // - every pin input lags two cycles, so an event and a read in one
  //   cycle are ordered by the synchroniser, not by the pins
  // - the reset pin acts two cycles late and lets go two cycles late;
  //   the host must leave the bank alone for two edges after release
  // - read and write strobes are never raised together by the host
  // - the read data register keeps its last answer between reads
endmodule : rfa_bank

// ==== test/rfa_bank_checker.sv ====
// port checker for the field access bank
`timescale 1ns/1ps
module rfa_bank_checker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire rfa_pkg::rfa_req_t req,
  input wire rfa_pkg::rfa_rsp_t rsp,
  input wire logic [7:0] wo_value,
  input wire logic [7:0] sc_pulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // read answer timing and write-only read data
  rd_answer_a: assert property (req.rd |=> rsp.valid)
    else $error("read not answered");
  rd_once_a: assert property (!req.rd |=> !rsp.valid)
    else $error("answer without read");
  wo_read_a: assert property (req.rd && req.addr == 3'h2 |=> rsp.rdata == 0)
    else $error("write-only read not zero");
  // write-only store
  wo_store_a: assert property (req.wr && req.addr == 3'h2 |=> wo_value == $past(req.wdata))
    else $error("write-only value not stored");
  wo_keep_a: assert property (!(req.wr && req.addr == 3'h2) |=> $stable(wo_value))
    else $error("write-only value moved");
  // self-clearing pulse and quiet outputs in reset
  sc_set_a: assert property (req.wr && req.addr == 3'h6 |=> sc_pulse == $past(req.wdata))
    else $error("self-clearing bit not set");
  sc_clear_a: assert property (!(req.wr && req.addr == 3'h6) |=> sc_pulse == 0)
    else $error("self-clearing bit stuck");
  rst_quiet_a: assert property (disable iff (1'b0) !rst_n [*3] |=> !rsp.valid && sc_pulse == 0)
    else $error("outputs active in reset");
endmodule : rfa_bank_checker
bind rfa_bank rfa_bank_checker u_chk (.*);

// ==== test/rfa_host.sv ====
// host model issuing one-cycle requests
`timescale 1ns/1ps
module rfa_host (
  output rfa_pkg::rfa_req_t req,
  input wire logic clk_sys
);
  import rfa_pkg::*;
  initial req = '0;
  // one request on a falling edge, never read and write together
  task automatic acc(input logic rd, input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_sys) req <= {rd, !rd, a[2:0], d};
    @(negedge clk_sys) req <= '0;
  endtask : acc
endmodule : rfa_host

// ==== test/rfa_bank_tb_top.sv ====
// self-checking bench for the field access bank
`timescale 1ns/1ps
module rfa_bank_tb_top;
  import rfa_pkg::*;
  logic clk_sys = 0, rst_n = 0;
  logic [7:0] rc_event = 0, ll_cond = 8'hff, lh_cond = 0, wo_value, sc_pulse;
  logic [7:0] ro_value = 8'h5a;
  rfa_req_t req;
  rfa_rsp_t rsp;
  int num_errors = 0, comparisons = 0;
  // rows: address nibble, write data, expected read
  logic [19:0] rows [10] = '{20'h0ff5a, 20'h10081, 20'h10000, 20'h30180,
    20'h23c00, 20'h60000, 20'h400fe, 20'h400ff, 20'h50010, 20'h50000};
  rfa_bank DUT (.clk_sys(clk_sys), .rst_n(rst_n), .req(req),
    .ro_value(ro_value), .rc_event(rc_event), .ll_cond(ll_cond),
    .lh_cond(lh_cond), .rsp(rsp), .wo_value(wo_value), .sc_pulse(sc_pulse));
  rfa_host u_host (.req(req), .clk_sys(clk_sys));
  initial forever #20 clk_sys = !clk_sys;
  task automatic chk(input string n, input logic [7:0] e, g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("errors %0d of %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  // cycle ceiling against a hang
  initial begin
    repeat (600) @(posedge clk_sys);
    num_errors++;
    report_and_stop();
  end
  // events, table, then hand cases and a second reset
  initial begin
    repeat (5) @(negedge clk_sys);
    rst_n = 1;
    {rc_event, ll_cond, lh_cond} = 24'h81fe10;
    repeat (4) @(negedge clk_sys);
    {rc_event, ll_cond, lh_cond} = 24'h00ff00;
    repeat (4) @(negedge clk_sys);
    foreach (rows[i]) begin
      u_host.acc(0, rows[i][19:16], rows[i][15:8]);
      u_host.acc(1, rows[i][19:16], 8'h00);
      chk("rdata", rows[i][7:0], rsp.rdata);
    end
    u_host.acc(0, 4'h6, 8'h01);
    chk("sc_pulse", 8'h01, sc_pulse);
    u_host.acc(0, 4'h2, 8'ha5);
    chk("wo_value", 8'ha5, wo_value);
    ro_value = 8'hc3;
    repeat (3) @(negedge clk_sys);
    u_host.acc(1, 4'h0, 8'h00);
    chk("ro live", 8'hc3, rsp.rdata);
    rst_n = 0;
    repeat (5) @(negedge clk_sys);
    chk("wo reset", 8'h00, wo_value);
    report_and_stop();
  end
endmodule : rfa_bank_tb_top
